// *** inc/cct_defines.vh ***
// constants for the completion credit tracker
`ifndef CCT_DEFINES_VH
`define CCT_DEFINES_VH
// credit method selection codes
`define CCT_OUTSTANDING_LIMIT_METHOD 2'h0
`define CCT_PER_PACKET_CREDIT_METHOD 2'h1
`define CCT_PER_BOUNDARY_CREDIT_METHOD 2'h2
// boundary sizes in bytes
`define CCT_RCB_SMALL_BYTES 13'h0040
`define CCT_RCB_LARGE_BYTES 13'h0080
// log2 of boundary sizes and of one data credit
`define CCT_RCB_SMALL_LOG2 4'h6
`define CCT_RCB_LARGE_LOG2 4'h7
`define CCT_CREDIT_LOG2 4'h4
// max read request size encoding base: 000b is 128 bytes
`define CCT_MRRS_BASE_LOG2 4'h7
// receive buffer pools
`define CCT_HDR_POOL 16'h0040
`define CCT_DATA_POOL_GOOD 16'h01f0
`define CCT_DATA_POOL_HIGH 16'h03e0
`endif

// *** hdl/cct_credit_calc.v ***
// combinational credit arithmetic for one request
`timescale 1ns/1ps
`include "cct_defines.vh"
module cct_credit_calc #(
	parameter METHOD = 2'h1
) (
	input  wire        rcbLarge,
	input  wire [11:0] startAddr,
	input  wire [12:0] reqBytes,
	input  wire        ioWrite,
	output wire [7:0]  hdrCredits,
	output wire [9:0]  dataCredits,
	output wire [4:0]  creditsPerBlock
);
	// ----------------------------------------------------------------
	// ceiling of (offset + size) / 2^shift
	// ----------------------------------------------------------------
	function [13:0] ceilBlocks;
		input [11:0] addr;
		input [12:0] size;
		input [3:0]  shift;
		reg   [13:0] sum;
		reg   [11:0] mask;
		begin
			mask = (12'h001 << shift) - 12'h001;
			sum = {2'h0, addr & mask} + {1'h0, size} + {2'h0, mask};
			ceilBlocks = sum >> shift;
		end
	endfunction

	wire [3:0]  rcbLog2 = rcbLarge ? `CCT_RCB_LARGE_LOG2 : `CCT_RCB_SMALL_LOG2;
	wire [13:0] hdrFull = ceilBlocks(startAddr, reqBytes, rcbLog2);
	wire [13:0] pktData = ceilBlocks(startAddr, reqBytes, `CCT_CREDIT_LOG2);

	// 64 bytes is 4 credits, 128 bytes is 8
	assign creditsPerBlock = rcbLarge ? 5'h08 : 5'h04;
	assign hdrCredits = hdrFull[7:0];
	// i/o writes return no data; boundary method rounds to whole blocks
	assign dataCredits = ioWrite ? 10'h000 :
		(METHOD == `CCT_PER_BOUNDARY_CREDIT_METHOD) ?
		{hdrFull[6:0], 3'h0} >> (rcbLarge ? 0 : 1) :
		pktData[9:0];
endmodule

// *** hdl/cct_tracker.v ***
// completion credit tracker gating non-posted requests
//
// Operation
// - boundary per function from two-bit status
// - unsampled boundary defaults to 64 bytes
// - status 0 is 64B, 1 is 128B
// - completions split only on boundary multiples
// - middle completions are whole boundary multiples
// - header credits equal boundary blocks occupied
// - limit method derives packets per pool
// - outstanding maximum is smaller pool count
// - outstanding count stays within zero and maximum
// - pending header and data counters reset zero
// - header credits ceiling offset plus size
// - packet data credits in 16-byte units
// - per-packet sends if sum at most pool
// - per-packet releases remembered credits at end
// - data credits per block is rcb/16
// - boundary data credits header times per-block
// - per-boundary sends if sum strictly below pool
// - per-boundary releases per block crossed
// - crossings from lower address and length
// - max read request field, default 128B
`timescale 1ns/1ps
`include "cct_defines.vh"
module cct_tracker #(
	parameter METHOD      = `CCT_PER_PACKET_CREDIT_METHOD,
	parameter HIGH_PERF   = 1,
	parameter TAG_BITS    = 5,
	parameter USE_STATUS  = 1
) (
	input  wire                mclk,
	input  wire                rst,
	// configuration status from the core
	input  wire [1:0]          rcbStatus,
	input  wire [2:0]          maxReadReqField,
	// request side
	input  wire                reqValid,
	output wire                reqReady,
	input  wire                reqFunc,
	input  wire [TAG_BITS-1:0] reqTag,
	input  wire [11:0]         reqAddr,
	input  wire [12:0]         reqBytes,
	input  wire                reqIoWrite,
	// completion side, one header beat per valid
	input  wire                cplValid,
	input  wire                cplFunc,
	input  wire [TAG_BITS-1:0] cplTag,
	input  wire [6:0]          cplLowerAddr,
	input  wire [12:0]         cplBytes,
	input  wire                cplLast,
	// status
	output reg  [7:0]          outstandingRequestCount,
	output reg  [7:0]          maxOutstandingRequests,
	output reg  [15:0]         pendingHeaderCredits,
	output reg  [15:0]         pendingDataCredits
);
	localparam DEPTH = 1 << TAG_BITS;
	localparam [15:0] DATA_POOL = HIGH_PERF ? `CCT_DATA_POOL_HIGH
		: `CCT_DATA_POOL_GOOD;
	localparam [15:0] HDR_POOL = `CCT_HDR_POOL;

	// ----------------------------------------------------------------
	// configuration, sampled from the core
	// ----------------------------------------------------------------
	// unsampled status reads as 64 byte boundary and 128 byte request
	reg [1:0] rcbReg;
	reg [2:0] mrrsReg;
	always @(posedge mclk) begin
		if (rst) begin
			rcbReg <= 2'h0;
			mrrsReg <= 3'h0;
		end else if (USE_STATUS != 0) begin
			rcbReg <= rcbStatus;
			mrrsReg <= (maxReadReqField > 3'h5) ? 3'h5 : maxReadReqField;
		end
	end

	// ----------------------------------------------------------------
	// boundary bit of one physical function
	// ----------------------------------------------------------------
	function pickRcb;
		input [1:0] status;
		input       func;
		begin
			pickRcb = func ? status[1] : status[0];
		end
	endfunction

	// each function uses its own boundary setting
	wire reqRcbLarge = pickRcb(rcbReg, reqFunc);
	wire cplRcbLarge = pickRcb(rcbReg, cplFunc);

	// ----------------------------------------------------------------
	// per request credits
	// ----------------------------------------------------------------
	wire [7:0] requestHeaderCredits;
	wire [9:0] requestDataCredits;
	wire [4:0] dataCreditsPerBlock;
	cct_credit_calc #(
		.METHOD (METHOD)
	) uCalc (
		.rcbLarge        (reqRcbLarge),
		.startAddr       (reqAddr),
		.reqBytes        (reqBytes),
		.ioWrite         (reqIoWrite),
		.hdrCredits      (requestHeaderCredits),
		.dataCredits     (requestDataCredits),
		.creditsPerBlock (dataCreditsPerBlock)
	);

	// ----------------------------------------------------------------
	// outstanding limit derivation
	// ----------------------------------------------------------------
	// headers per max request is ceiling(mrrs/rcb); both powers of two
	reg [3:0]  mrrsLog2;
	reg [3:0]  rcbLog2;
	reg [7:0]  hdrPerMax;
	reg [15:0] pktByData;
	reg [15:0] pktByHdr;
	always @* begin
		mrrsLog2 = `CCT_MRRS_BASE_LOG2 + {1'h0, mrrsReg};
		rcbLog2 = rcbReg[0] ? `CCT_RCB_LARGE_LOG2 : `CCT_RCB_SMALL_LOG2;
		hdrPerMax = 8'h01 << (mrrsLog2 - rcbLog2);
		pktByData = DATA_POOL >> (mrrsLog2 - `CCT_CREDIT_LOG2);
		pktByHdr = HDR_POOL >> (mrrsLog2 - rcbLog2);
	end
	// limit tracks function 0's boundary, the conservative default

	always @(posedge mclk) begin
		if (rst) begin
			maxOutstandingRequests <= 8'h00;
		end else begin
			maxOutstandingRequests <= (pktByHdr < pktByData) ?
				pktByHdr[7:0] : pktByData[7:0];
		end
	end

	// ----------------------------------------------------------------
	// per tag memory of credits granted (per-packet method)
	// ----------------------------------------------------------------
	reg [7:0] tagHdr  [0:DEPTH-1];
	reg [9:0] tagData [0:DEPTH-1];

	// ----------------------------------------------------------------
	// completion boundary crossings
	// ----------------------------------------------------------------
	// ceiling((lower address mod rcb + length) / rcb)
	wire [6:0]  cplMask = cplRcbLarge ? 7'h7f : 7'h3f;
	wire [13:0] cplSum = {7'h00, cplLowerAddr & cplMask}
		+ {1'h0, cplBytes} + {7'h00, cplMask};
	wire [7:0]  boundaryCrossings = cplRcbLarge ? {1'b0, cplSum[13:7]} :
		cplSum[13:6];
	wire [15:0] relHdrBlk = {8'h00, boundaryCrossings};
	wire [15:0] relDataBlk = {8'h00, boundaryCrossings}
		<< (cplRcbLarge ? 3 : 2);

	// ----------------------------------------------------------------
	// admission
	// ----------------------------------------------------------------
	wire [15:0] sumHdr = pendingHeaderCredits + {8'h00, requestHeaderCredits};
	wire [15:0] sumData = pendingDataCredits + {6'h00, requestDataCredits};
	reg admit;
	always @* begin
		case (METHOD)
		`CCT_OUTSTANDING_LIMIT_METHOD: begin
			admit = outstandingRequestCount < maxOutstandingRequests;
		end
		`CCT_PER_PACKET_CREDIT_METHOD: begin
			admit = (sumHdr <= HDR_POOL) && (sumData <= DATA_POOL);
		end
		`CCT_PER_BOUNDARY_CREDIT_METHOD: begin
			admit = (sumHdr < HDR_POOL) && (sumData < DATA_POOL);
		end
		default: begin
			admit = 1'b0;
		end
		endcase
	end
	// ready only in the method's own headroom; blocks until freed
	assign reqReady = admit;
	wire sendFire = reqValid && admit;
	wire cplDone = cplValid && cplLast;

	// ----------------------------------------------------------------
	// tag memory write
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (sendFire) begin
			tagHdr[reqTag] <= requestHeaderCredits;
			tagData[reqTag] <= requestDataCredits;
		end
	end

	// ----------------------------------------------------------------
	// release amounts per method
	// ----------------------------------------------------------------
	reg [15:0] relHdr;
	reg [15:0] relData;
	always @* begin
		relHdr = 16'h0000;
		relData = 16'h0000;
		if (METHOD == `CCT_PER_PACKET_CREDIT_METHOD && cplDone) begin
			relHdr = {8'h00, tagHdr[cplTag]};
			relData = {6'h00, tagData[cplTag]};
		end else if (METHOD == `CCT_PER_BOUNDARY_CREDIT_METHOD && cplValid)
		begin
			relHdr = relHdrBlk;
			relData = relDataBlk;
		end
	end

	// ----------------------------------------------------------------
	// pending counters: sends and releases in the same cycle both count
	// ----------------------------------------------------------------
	reg [15:0] next_hdr;
	reg [15:0] next_data;
	always @* begin
		next_hdr = pendingHeaderCredits;
		next_data = pendingDataCredits;
		if (sendFire) begin
			next_hdr = next_hdr + {8'h00, requestHeaderCredits};
			next_data = next_data + {6'h00, requestDataCredits};
		end
		// saturate at zero so a stray completion cannot wrap
		next_hdr = (next_hdr > relHdr) ? next_hdr - relHdr : 16'h0000;
		next_data = (next_data > relData) ? next_data - relData : 16'h0000;
	end

	always @(posedge mclk) begin
		if (rst) begin
			pendingHeaderCredits <= 16'h0000;
			pendingDataCredits <= 16'h0000;
		end else if (METHOD != `CCT_OUTSTANDING_LIMIT_METHOD) begin
			pendingHeaderCredits <= next_hdr;
			pendingDataCredits <= next_data;
		end
	end

	// ----------------------------------------------------------------
	// outstanding request counter
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (rst) begin
			outstandingRequestCount <= 8'h00;
		end else if (METHOD == `CCT_OUTSTANDING_LIMIT_METHOD) begin
			if (sendFire && !cplDone) begin
				outstandingRequestCount <= outstandingRequestCount + 8'h01;
			end else if (cplDone && !sendFire &&
				outstandingRequestCount != 8'h00) begin
				outstandingRequestCount <= outstandingRequestCount - 8'h01;
			end
		end
	end
endmodule

// *** testbench/cct_tracker_asserts.sv ***
// port assertions for the completion credit tracker
`timescale 1ns/1ps
module cct_tracker_asserts #(
	parameter HIGH_PERF = 1,
	parameter METHOD    = 1
) (
	input wire        mclk,
	input wire        rst,
	input wire        reqValid,
	input wire        reqReady,
	input wire [11:0] reqAddr,
	input wire [12:0] reqBytes,
	input wire        cplValid,
	input wire [7:0]  outstandingRequestCount,
	input wire [7:0]  maxOutstandingRequests,
	input wire [15:0] pendingHeaderCredits,
	input wire [15:0] pendingDataCredits
);
	// ----------
	// properties
	// ----------
	localparam int DPOOL = HIGH_PERF ? 992 : 496;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire sendNow = reqValid && reqReady;
	// a refused request offered again unchanged
	sequence heldRefused;
		reqValid && !reqReady && !cplValid ##1
			reqValid && $stable(reqAddr) && $stable(reqBytes);
	endsequence
	reset_clears_a: assert property ($fell(rst) |->
		pendingHeaderCredits == 16'h0 && pendingDataCredits == 16'h0)
		else $error("counters not cleared by reset");
	hdr_pool_a: assert property (pendingHeaderCredits <= 64)
		else $error("header credits beyond pool");
	data_pool_a: assert property (pendingDataCredits <= DPOOL)
		else $error("data credits beyond pool");
	hdr_send_only_a: assert property (!sendNow |=>
		pendingHeaderCredits <= $past(pendingHeaderCredits))
		else $error("header credits rose without a send");
	data_send_only_a: assert property (!sendNow |=>
		pendingDataCredits <= $past(pendingDataCredits))
		else $error("data credits rose without a send");
	hdr_release_only_a: assert property (!cplValid |=>
		pendingHeaderCredits >= $past(pendingHeaderCredits))
		else $error("header credits fell without a completion");
	// the limit method keeps no pending credits, so skip it there
	send_grows_a: assert property (
		METHOD != 0 && sendNow && !cplValid |=>
		pendingHeaderCredits > $past(pendingHeaderCredits))
		else $error("send did not reserve header credits");
	refusal_holds_a: assert property (heldRefused |-> !reqReady)
		else $error("refused request admitted without a release");
	count_bound_a: assert property (
		outstandingRequestCount <= maxOutstandingRequests)
		else $error("outstanding count above maximum");
endmodule
bind cct_tracker cct_tracker_asserts #(.HIGH_PERF(HIGH_PERF),
	.METHOD(METHOD)) chk (
	.mclk(mclk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
	.reqAddr(reqAddr), .reqBytes(reqBytes), .cplValid(cplValid),
	.outstandingRequestCount(outstandingRequestCount),
	.maxOutstandingRequests(maxOutstandingRequests),
	.pendingHeaderCredits(pendingHeaderCredits),
	.pendingDataCredits(pendingDataCredits));

// *** testbench/cct_core_model.sv ***
// behavioural endpoint core: status outputs and completion headers
`timescale 1ns/1ps
module cct_core_model (
	input  wire        mclk,
	output reg  [1:0]  rcbStatus,
	output reg  [2:0]  maxReadReqField,
	output reg         cplValid,
	output reg  [4:0]  cplTag,
	output reg         cplFunc,
	output reg  [6:0]  cplLowerAddr,
	output reg  [12:0] cplBytes,
	output reg         cplLast
);
	// function 0 at 64 bytes, function 1 at 128 bytes
	initial begin
		rcbStatus = 2'h2;
		maxReadReqField = 3'h0; // 128 byte requests
		cplValid = 1'b0;
		{cplTag, cplFunc, cplLowerAddr, cplBytes, cplLast} = 27'h0;
	end
	// one header beat; released fields show inverted junk, not old data
	task complete(input [4:0] t, input f, input [6:0] la,
		input [12:0] n, input last);
		@(negedge mclk);
		{cplTag, cplFunc, cplLowerAddr, cplBytes, cplLast} = {t, f, la, n, last};
		cplValid = 1'b1;
		@(negedge mclk);
		cplValid = 1'b0;
		{cplTag, cplFunc, cplLowerAddr, cplBytes, cplLast} =
			~{cplTag, cplFunc, cplLowerAddr, cplBytes, cplLast};
	endtask
endmodule

// *** testbench/cct_tracker_bench.sv ***
// self-checking bench for the completion credit tracker
`timescale 1ns/1ps
`include "cct_defines.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
	bad_count++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module cct_tracker_bench;
	reg         mclk = 1'b0;
	reg         rst = 1'b1;
	reg         reqValid = 1'b0;
	reg         reqFunc = 1'b0;
	reg         reqIoWrite = 1'b0;
	reg  [4:0]  reqTag = 5'h0;
	reg  [11:0] reqAddr = 12'h0;
	reg  [12:0] reqBytes = 13'h0;
	wire [1:0]  rcbStatus;
	wire [2:0]  maxReadReqField;
	wire        reqReady, cplValid, cplFunc, cplLast;
	wire [4:0]  cplTag;
	wire [6:0]  cplLowerAddr;
	wire [12:0] cplBytes;
	wire [7:0]  outCount, outMax;
	wire [15:0] hdrPend, dataPend;
	// companion trackers in the other two methods, same stimulus
	wire        rdyB, rdyL;
	wire [7:0]  cntB, maxB, cntL, maxL;
	wire [15:0] hB, dB, hL, dL;
	integer     bad_count = 0;
	integer     total_checks = 0;
	integer     cyc = 0;
	// ----------
	// structure
	// ----------
	always #20 mclk = ~mclk;
	cct_core_model core (.mclk(mclk), .rcbStatus(rcbStatus),
		.maxReadReqField(maxReadReqField), .cplValid(cplValid),
		.cplTag(cplTag), .cplFunc(cplFunc), .cplLowerAddr(cplLowerAddr),
		.cplBytes(cplBytes), .cplLast(cplLast));
	cct_tracker #(.METHOD(`CCT_PER_PACKET_CREDIT_METHOD), .HIGH_PERF(1),
		.TAG_BITS(5), .USE_STATUS(1)) DUT (.mclk(mclk), .rst(rst),
		.rcbStatus(rcbStatus), .maxReadReqField(maxReadReqField),
		.reqValid(reqValid), .reqReady(reqReady), .reqFunc(reqFunc),
		.reqTag(reqTag), .reqAddr(reqAddr), .reqBytes(reqBytes),
		.reqIoWrite(reqIoWrite), .cplValid(cplValid), .cplFunc(cplFunc),
		.cplTag(cplTag), .cplLowerAddr(cplLowerAddr), .cplBytes(cplBytes),
		.cplLast(cplLast), .outstandingRequestCount(outCount),
		.maxOutstandingRequests(outMax), .pendingHeaderCredits(hdrPend),
		.pendingDataCredits(dataPend));
	cct_tracker #(.METHOD(`CCT_PER_BOUNDARY_CREDIT_METHOD), .HIGH_PERF(1),
		.TAG_BITS(5), .USE_STATUS(1)) DUT_RCB (.mclk(mclk), .rst(rst),
		.rcbStatus(rcbStatus), .maxReadReqField(maxReadReqField),
		.reqValid(reqValid), .reqReady(rdyB), .reqFunc(reqFunc),
		.reqTag(reqTag), .reqAddr(reqAddr), .reqBytes(reqBytes),
		.reqIoWrite(reqIoWrite), .cplValid(cplValid), .cplFunc(cplFunc),
		.cplTag(cplTag), .cplLowerAddr(cplLowerAddr), .cplBytes(cplBytes),
		.cplLast(cplLast), .outstandingRequestCount(cntB),
		.maxOutstandingRequests(maxB), .pendingHeaderCredits(hB),
		.pendingDataCredits(dB));
	cct_tracker #(.METHOD(`CCT_OUTSTANDING_LIMIT_METHOD), .HIGH_PERF(1),
		.TAG_BITS(5), .USE_STATUS(1)) DUT_LIM (.mclk(mclk), .rst(rst),
		.rcbStatus(rcbStatus), .maxReadReqField(maxReadReqField),
		.reqValid(reqValid), .reqReady(rdyL), .reqFunc(reqFunc),
		.reqTag(reqTag), .reqAddr(reqAddr), .reqBytes(reqBytes),
		.reqIoWrite(reqIoWrite), .cplValid(cplValid), .cplFunc(cplFunc),
		.cplTag(cplTag), .cplLowerAddr(cplLowerAddr), .cplBytes(cplBytes),
		.cplLast(cplLast), .outstandingRequestCount(cntL),
		.maxOutstandingRequests(maxL), .pendingHeaderCredits(hL),
		.pendingDataCredits(dL));
	// ----------
	// helpers
	// ----------
	// offer a request at the falling edge, hold it until admitted
	task send(input f, input [11:0] a, input [12:0] n, input io,
		input [4:0] t);
		integer i;
		@(negedge mclk);
		{reqFunc, reqAddr, reqBytes, reqIoWrite, reqTag} = {f, a, n, io, t};
		reqValid = 1'b1;
		#1;
		for (i = 0; i < 50 && reqReady !== 1'b1; i++) begin
			@(negedge mclk);
			#1;
		end
		`CHK(reqReady, 1'b1)
		@(negedge mclk);
		reqValid = 1'b0;
	endtask
	task pend(input [15:0] h, input [15:0] d);
		#1;
		`CHK(hdrPend, h)
		`CHK(dataPend, d)
	endtask
	// ----------
	// scenarios
	// ----------
	task t_packet;
		send(1'b0, 12'h07c, 13'h0008, 1'b0, 5'h1);
		pend(16'h2, 16'h2);
		`CHK(hB, 16'h2)
		`CHK(dB, 16'h8)
		`CHK(cntL, 8'h01)
		core.complete(5'h1, 1'b0, 7'h7c, 13'h0004, 1'b0);
		pend(16'h2, 16'h2);
		`CHK(hB, 16'h1)
		`CHK(dB, 16'h4)
		`CHK(cntL, 8'h01)
		core.complete(5'h1, 1'b0, 7'h00, 13'h0004, 1'b1);
		pend(16'h0, 16'h0);
		`CHK(hB, 16'h0)
		`CHK(dB, 16'h0)
		`CHK(cntL, 8'h00)
		$display("done: packet");
	endtask
	task t_func;
		send(1'b1, 12'h020, 13'h0040, 1'b0, 5'h2);
		pend(16'h1, 16'h4);
		send(1'b0, 12'h020, 13'h0040, 1'b0, 5'h3);
		pend(16'h3, 16'h8);
		core.complete(5'h2, 1'b1, 7'h20, 13'h0040, 1'b1);
		core.complete(5'h3, 1'b0, 7'h20, 13'h0040, 1'b1);
		pend(16'h0, 16'h0);
		send(1'b0, 12'h000, 13'h0004, 1'b1, 5'h4);
		pend(16'h1, 16'h0);
		core.complete(5'h4, 1'b0, 7'h00, 13'h0000, 1'b1);
		pend(16'h0, 16'h0);
		$display("done: function and io");
	endtask
	// exactly filling the header pool is allowed, one more is held off
	task t_pool;
		send(1'b0, 12'h000, 13'h1000, 1'b0, 5'h5);
		pend(16'h40, 16'h100);
		@(negedge mclk);
		{reqAddr, reqBytes, reqTag} = {12'h0, 13'h4, 5'h6};
		reqValid = 1'b1;
		repeat (3) @(negedge mclk);
		#1;
		`CHK(reqReady, 1'b0)
		reqValid = 1'b0;
		core.complete(5'h5, 1'b0, 7'h00, 13'h1000, 1'b1);
		send(1'b0, 12'h000, 13'h0004, 1'b0, 5'h6);
		pend(16'h1, 16'h1);
		core.complete(5'h6, 1'b0, 7'h00, 13'h0004, 1'b1);
		pend(16'h0, 16'h0);
		$display("done: pool");
	endtask
	// ----------
	// run control
	// ----------
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// whole run is a few dozen cycles, so this only trips on a hang
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		pend(16'h0, 16'h0);
		`CHK(outMax, 8'h20)
		`CHK(maxL, 8'h20)
		`CHK(cntL, 8'h00)
		`CHK(hB, 16'h0)
		t_packet;
		t_func;
		t_pool;
		tally_and_finish;
	end
endmodule
